// File: design/trip_unit_panel_sequencer.sv
`timescale 1ns/100ps
`include "trip_params.svh"
module trip_unit_panel_sequencer
  import trip_pkg::*;
#(
  parameter int HAS_S = 1, // Selective protection fitted
  parameter int HAS_G = 1, // Ground-fault protection fitted
  parameter int MS_CYC = `CLK_KHZ, // Cycles per millisecond
  parameter int HOLD_CYC = `HOLD_MS * `CLK_KHZ, // Reset hold time
  parameter int RECALL_CYC = `RECALL_MS * `CLK_KHZ, // Recall lamp time
  parameter int DEB_CYC = `DEB_MS * `CLK_KHZ, // Debounce time
  parameter int BLINK_CYC = `BLINK_MS * `CLK_KHZ // Half blink period
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Async reset, low active
  input wire logic ce, // Clock enable, freezes state
  input wire logic pwr_ok, // Sensor or auxiliary supply good
  input wire logic test_module_present, // Front module powers unit
  input wire logic test_trip_req, // Trip test from front module
  input wire logic front_pushbutton, // Pressed is high
  input wire logic [3:0] overload_threshold, // Switch code, 0 off
  input wire logic [3:0] selective_short_threshold, // Switch code
  input wire logic [3:0] instantaneous_threshold, // Switch code
  input wire logic [3:0] ground_fault_threshold, // Switch code
  input wire logic [2:0] overload_delay, // Delay code
  input wire logic [2:0] selective_short_delay, // Delay code
  input wire logic [2:0] ground_fault_delay, // Delay code
  input wire logic curve_sel_short, // Inverse curve, selective
  input wire logic curve_sel_ground, // Inverse curve, ground
  input wire logic [1:0] neutral_sel, // Neutral off/50/100/200
  input wire logic freq_sel_60, // Installation at 60 Hz
  input wire logic [15:0] rating_amps, // Rated current of module
  input wire logic [15:0] meas_phase, // Highest phase current
  input wire logic [15:0] meas_neutral, // Neutral current
  input wire logic [15:0] meas_ground, // Ground current
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [`AW-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  output logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  input wire logic [`AW-1:0] s_axi_araddr, // Read address
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic led_overload, // Overload alarm and trip lamp
  output logic led_overload_pre, // Overload pre-alarm lamp
  output logic led_selective, // Selective short lamp
  output logic led_instant, // Instantaneous trip lamp
  output logic led_ground, // Ground-fault lamp
  output logic led_power, // Power-on lamp
  output logic trip_coil, // Trip coil command
  output logic freq_60hz, // Frequency to measurement side
  output logic irq // Level interrupt
);

  state_t q; // Current state
  state_t n; // Next state
  logic rst_s1; // Reset synchroniser, first stage
  logic rst_sync_n; // Released reset copy
  logic energized; // Unit has power from any source
  set_t sw_raw; // Switch bank as sampled
  set_t a; // Applied settings
  logic [16:0] meas_nscaled; // Neutral scaled to phase terms
  logic [16:0] meas_l; // Current seen by overload
  logic [`NPROT-1:0][16:0] meas_a; // Current per protection
  logic [`NPROT-1:0][3:0] code_a; // Threshold code per protection
  logic [`NPROT-1:0][7:0] step_a; // Threshold step per protection
  logic [`NPROT-1:0][2:0] dcode_a; // Delay code per protection
  logic [`NPROT-1:0][15:0] dunit_a; // Delay step per protection
  logic [`NPROT-1:0] inv_a; // Inverse curve selected
  logic [`NPROT-1:0] fit_a; // Protection fitted
  logic [`NPROT-1:0] en; // Protection enabled
  logic [`NPROT-1:0] over; // Above threshold
  logic [`NPROT-1:0] pre; // Above pre-alarm level
  logic [`NPROT-1:0][`ACC_W-1:0] target; // Delay in acc units
  logic [`NPROT-1:0][7:0] inc; // Acc step per millisecond

  // Reset released through two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_sync_n <= rst_s1;
    end
  end

  // Test module powers the unit as well as its own supply
  assign energized = pwr_ok | test_module_present;
  assign sw_raw = '{thr_l: overload_threshold,
                    thr_s: selective_short_threshold,
                    thr_i: instantaneous_threshold,
                    thr_g: ground_fault_threshold,
                    dly_l: overload_delay,
                    dly_s: selective_short_delay,
                    dly_g: ground_fault_delay,
                    curve_s: curve_sel_short,
                    curve_g: curve_sel_ground,
                    neutral: neutral_sel,
                    freq_60: freq_sel_60};
  assign a = q.applied;

  // Neutral scaled so that one threshold serves both
  always_comb begin
    unique case (a.neutral)
      2'h1: meas_nscaled = {meas_neutral, 1'b0};
      2'h2: meas_nscaled = {1'b0, meas_neutral};
      2'h3: meas_nscaled = {2'h0, meas_neutral[15:1]};
      default: meas_nscaled = 17'h00000;
    endcase
    meas_l = {1'b0, meas_phase};
    if (meas_nscaled > meas_l) begin
      meas_l = meas_nscaled;
    end
  end

  // Per-protection settings gathered by index
  assign meas_a = {{1'b0, meas_ground}, {1'b0, meas_phase},
                   {1'b0, meas_phase}, meas_l};
  assign code_a = {a.thr_g, a.thr_i, a.thr_s, a.thr_l};
  assign step_a = {`STEP_G, `STEP_I, `STEP_S, `STEP_L};
  assign dcode_a = {a.dly_g, 3'h0, a.dly_s, a.dly_l};
  assign dunit_a = {`DUNIT_G, `DUNIT_I, `DUNIT_S, `DUNIT_L};
  assign inv_a = {a.curve_g, 1'b0, a.curve_s, 1'b1};
  assign fit_a = {HAS_G != 0, 1'b1, HAS_S != 0, 1'b1};

  // Threshold, pre-alarm and delay per protection
  for (genvar gi = 0; gi < `NPROT; gi++) begin : g_prot
    logic [11:0] mult; // Threshold in sixteenths of rating
    logic [27:0] thr_full; // Rating times multiple
    logic [27:0] thr; // Threshold in amps
    logic [27:0] m28; // Current widened
    logic [23:0] dms; // Delay in milliseconds
    assign mult = 12'(code_a[gi]) * 12'(step_a[gi]);
    assign thr_full = 28'(rating_amps) * 28'(mult);
    assign thr = thr_full >> `FRAC_SH;
    assign m28 = 28'(meas_a[gi]);
    assign en[gi] = fit_a[gi] && (code_a[gi] != 4'h0);
    assign over[gi] = en[gi] && (m28 > thr);
    assign pre[gi] = en[gi] && (m28 > (thr - (thr >> `PRE_SH)));
    assign dms = (24'(dcode_a[gi]) + 24'h000001) * 24'(dunit_a[gi]);
    assign target[gi] = dms << `FRAC_SH;
    // Stepwise inverse time, cheaper than a divider
    always_comb begin
      if (!inv_a[gi]) begin
        inc[gi] = `INC_BASE;
      end else if (m28 >= (thr << 3)) begin
        inc[gi] = `INC_X8;
      end else if (m28 >= (thr << 2)) begin
        inc[gi] = `INC_X4;
      end else if (m28 >= (thr << 1)) begin
        inc[gi] = `INC_X2;
      end else begin
        inc[gi] = `INC_BASE;
      end
    end
  end

  // All next-state logic
  always_comb begin
    logic tick; // Millisecond strobe
    logic any_alarm; // Any protection timing or tripped
    logic btn_rise; // Debounced press edge
    logic clr_ind; // Clear trip indication
    logic [`NPROT-1:0] trip_ev; // Trips this cycle
    logic pre_ev; // Pre-alarm entry this cycle
    logic set_ev; // Settings applied this cycle
    logic [`ACC_W:0] sum; // Accumulator plus step
    logic do_wr; // Register write this cycle
    logic [`EV_W-1:0] w1c; // Bits software clears
    logic [`EV_W-1:0] ev; // Interrupt events
    tick = 1'b0;
    any_alarm = 1'b0;
    btn_rise = 1'b0;
    clr_ind = 1'b0;
    trip_ev = '0;
    pre_ev = 1'b0;
    set_ev = 1'b0;
    sum = '0;
    do_wr = 1'b0;
    w1c = '0;
    ev = '0;
    n = q;

    // Two-flop sync then stable-count debounce
    n.sw_s1 = sw_raw;
    n.sw_s2 = q.sw_s1;
    n.btn_s1 = front_pushbutton;
    n.btn_s2 = q.btn_s1;
    if (q.sw_s2 != q.sw_stable) begin
      n.sw_cnt = q.sw_cnt + 32'h1;
      if (q.sw_cnt >= 32'(DEB_CYC - 1)) begin
        n.sw_stable = q.sw_s2;
        n.sw_cnt = 32'h0;
      end
    end else begin
      n.sw_cnt = 32'h0;
    end
    if (q.btn_s2 != q.btn_db) begin
      n.btn_cnt = q.btn_cnt + 32'h1;
      if (q.btn_cnt >= 32'(DEB_CYC - 1)) begin
        n.btn_db = q.btn_s2;
        n.btn_cnt = 32'h0;
        btn_rise = q.btn_s2;
      end
    end else begin
      n.btn_cnt = 32'h0;
    end

    // Millisecond timebase for delays
    if (q.ms_cnt >= 32'(MS_CYC - 1)) begin
      n.ms_cnt = 32'h0;
      tick = 1'b1;
    end else begin
      n.ms_cnt = q.ms_cnt + 32'h1;
    end

    // Protection sequences
    for (int i = 0; i < `NPROT; i++) begin
      sum = (`ACC_W+1)'(q.acc[i]) + (`ACC_W+1)'(inc[i]);
      unique case (q.pst[i])
        P_IDLE: begin
          if (over[i]) begin
            n.pst[i] = P_TIME;
            n.acc[i] = '0;
          end else if (i == `P_L && pre[i]) begin
            n.pst[i] = P_PRE;
            pre_ev = 1'b1;
          end
        end
        P_PRE: begin
          if (over[i]) begin
            n.pst[i] = P_TIME;
            n.acc[i] = '0;
          end else if (!pre[i]) begin
            n.pst[i] = P_IDLE;
          end
        end
        P_TIME: begin
          if (!over[i]) begin
            n.pst[i] = P_IDLE;
          end else if (target[i] == '0 ||
                       (tick && sum >= (`ACC_W+1)'(target[i]))) begin
            n.pst[i] = P_TRIP;
            trip_ev[i] = 1'b1;
          end else if (tick) begin
            n.acc[i] = sum[`ACC_W-1:0];
          end
        end
        P_TRIP: begin
          if (!over[i]) begin
            n.pst[i] = P_IDLE;
          end
        end
      endcase
      // Disabled or unpowered protection falls back
      if (!en[i] || !energized) begin
        n.pst[i] = P_IDLE;
        trip_ev[i] = 1'b0;
      end
      if (q.pst[i] == P_TIME || q.pst[i] == P_TRIP) begin
        any_alarm = 1'b1;
      end
    end

    // New switch values wait for resting condition
    if (!any_alarm && q.applied != q.sw_stable) begin
      n.applied = q.sw_stable;
      set_ev = 1'b1;
    end

    // Long press, cleared when the button comes up
    if (q.btn_db && energized) begin
      if (q.hold_cnt >= 32'(HOLD_CYC - 1)) begin
        n.hold_done = 1'b1;
      end else begin
        n.hold_cnt = q.hold_cnt + 32'h1;
      end
    end else begin
      clr_ind = q.hold_done && !q.btn_db;
      n.hold_done = 1'b0;
      n.hold_cnt = 32'h0;
    end
    // A trip in the clearing cycle still lands
    n.trip_ind = (clr_ind ? '0 : q.trip_ind) | trip_ev;

    // Recall of the last event while unpowered
    if (energized) begin
      n.recall_on = 1'b0;
      n.recall_cnt = 32'h0;
    end else if (btn_rise) begin
      n.recall_on = 1'b1;
      n.recall_cnt = 32'h0;
    end else if (q.recall_on) begin
      if (q.recall_cnt >= 32'(RECALL_CYC - 1)) begin
        n.recall_on = 1'b0;
      end else begin
        n.recall_cnt = q.recall_cnt + 32'h1;
      end
    end

    // Blink source for the power lamp
    if (q.blink_cnt >= 32'(BLINK_CYC - 1)) begin
      n.blink_cnt = 32'h0;
      n.blink = !q.blink;
    end else begin
      n.blink_cnt = q.blink_cnt + 32'h1;
    end

    // Trip test only while the front module supplies power
    n.test_trip = test_trip_req && test_module_present;
    n.trip_coil = q.test_trip;
    for (int i = 0; i < `NPROT; i++) begin
      if (q.pst[i] == P_TRIP) begin
        n.trip_coil = 1'b1;
      end
    end

    // Lamps
    if (energized) begin
      n.led_ovl = q.pst[`P_L] inside {P_TIME, P_TRIP} ||
                  q.trip_ind[`P_L];
      n.led_pre = q.pst[`P_L] == P_PRE;
      n.led_sel = q.pst[`P_S] inside {P_TIME, P_TRIP} ||
                  q.trip_ind[`P_S];
      n.led_ins = q.trip_ind[`P_I];
      n.led_gnd = q.pst[`P_G] inside {P_TIME, P_TRIP} ||
                  q.trip_ind[`P_G];
      n.led_pwr = q.cfg_blink ? q.blink : 1'b1;
    end else begin
      // Battery mode: last event only, on request
      n.led_ovl = q.recall_on && q.trip_ind[`P_L];
      n.led_pre = 1'b0;
      n.led_sel = q.recall_on && q.trip_ind[`P_S];
      n.led_ins = q.recall_on && q.trip_ind[`P_I];
      n.led_gnd = q.recall_on && q.trip_ind[`P_G];
      n.led_pwr = q.recall_on && (q.trip_ind == '0);
    end
    // Absent protections have no lamp
    n.led_sel = n.led_sel && fit_a[`P_S];
    n.led_gnd = n.led_gnd && fit_a[`P_G];

    // Bus write channels, taken in either order
    if (s_axi_awvalid && q.awready) begin
      n.aw_have = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_have = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      do_wr = q.w_strb[0];
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OK;
      unique case (q.aw_addr)
        `OFS_CTRL: begin
          if (do_wr) begin
            n.cfg_blink = q.w_data[0];
          end
        end
        `OFS_IRQ_STAT: begin
          if (do_wr) begin
            w1c = q.w_data[`EV_W-1:0];
          end
        end
        `OFS_IRQ_MASK: begin
          if (do_wr) begin
            n.irq_mask = q.w_data[`EV_W-1:0];
          end
        end
        `OFS_STATUS, `OFS_SET: ;
        default: n.bresp = `RESP_ERR;
      endcase
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;

    // Bus read channel
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp = `RESP_OK;
      unique case (s_axi_araddr)
        `OFS_CTRL: n.rdata = 32'(q.cfg_blink);
        `OFS_STATUS: n.rdata = 32'({q.trip_coil, any_alarm,
                                    q.sw_stable != q.applied,
                                    energized, q.trip_ind, q.pst});
        `OFS_IRQ_STAT: n.rdata = 32'(q.irq_stat);
        `OFS_IRQ_MASK: n.rdata = 32'(q.irq_mask);
        `OFS_SET: n.rdata = 32'(q.applied);
        default: begin
          n.rdata = 32'h0;
          n.rresp = `RESP_ERR;
        end
      endcase
    end
    n.arready = !n.rvalid;

    // Sticky events, a new event beats the clear
    ev = {set_ev, pre_ev, trip_ev};
    n.irq_stat = (q.irq_stat & ~w1c) | ev;
    n.irq = |(q.irq_stat & q.irq_mask);

    // Clock enable low holds everything
    if (!ce) begin
      n = q;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q <= '0;
      for (int i = 0; i < `NPROT; i++) begin
        q.pst[i] <= P_IDLE;
      end
    end else begin
      q <= n;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign led_overload = q.led_ovl;
  assign led_overload_pre = q.led_pre;
  assign led_selective = q.led_sel;
  assign led_instant = q.led_ins;
  assign led_ground = q.led_gnd;
  assign led_power = q.led_pwr;
  assign trip_coil = q.trip_coil;
  assign freq_60hz = q.applied.freq_60;
  assign irq = q.irq;

endmodule : trip_unit_panel_sequencer

// File: design/trip_params.svh
`ifndef TRIP_PARAMS_SVH
`define TRIP_PARAMS_SVH

// Protection indexes
`define NPROT 4
`define P_L 0
`define P_S 1
`define P_I 2
`define P_G 3

// Clock and times in milliseconds
`define CLK_KHZ 250000
`define HOLD_MS 1000
`define RECALL_MS 4000
`define DEB_MS 10
`define BLINK_MS 500

// Register map, byte addresses
`define AW 8
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0C
`define OFS_SET 8'h10
`define RESP_OK 2'h0
`define RESP_ERR 2'h2

// Interrupt events: trips in low bits, then these
`define EV_W 6
`define EV_PRE 4
`define EV_SET 5

// Threshold steps in sixteenths of rated current
`define FRAC_SH 4
`define STEP_L 8'h02
`define STEP_S 8'h10
`define STEP_I 8'h20
`define STEP_G 8'h01
`define PRE_SH 3

// Delay step per switch code, milliseconds
`define DUNIT_L 16'h0BB8
`define DUNIT_S 16'h0032
`define DUNIT_I 16'h0000
`define DUNIT_G 16'h0064

// Delay accumulator
`define ACC_W 24
`define INC_BASE 8'h10
`define INC_X2 8'h20
`define INC_X4 8'h40
`define INC_X8 8'h80
`endif

// File: design/trip_pkg.sv
package trip_pkg;
`include "trip_params.svh"

  // Per-protection sequence
  typedef enum logic [3:0] {
    P_IDLE = 4'h1,
    P_PRE = 4'h2,
    P_TIME = 4'h4,
    P_TRIP = 4'h8
  } prot_state_t;

  // Switch settings as one word
  typedef struct packed {
    logic [3:0] thr_l;
    logic [3:0] thr_s;
    logic [3:0] thr_i;
    logic [3:0] thr_g;
    logic [2:0] dly_l;
    logic [2:0] dly_s;
    logic [2:0] dly_g;
    logic curve_s;
    logic curve_g;
    logic [1:0] neutral;
    logic freq_60;
  } set_t;

  // Whole state of the sequencer
  typedef struct packed {
    set_t sw_s1;
    set_t sw_s2;
    set_t sw_stable;
    set_t applied;
    logic [31:0] sw_cnt;
    logic btn_s1;
    logic btn_s2;
    logic btn_db;
    logic [31:0] btn_cnt;
    prot_state_t [`NPROT-1:0] pst;
    logic [`NPROT-1:0][`ACC_W-1:0] acc;
    logic [31:0] ms_cnt;
    logic [`NPROT-1:0] trip_ind;
    logic [31:0] hold_cnt;
    logic hold_done;
    logic [31:0] recall_cnt;
    logic recall_on;
    logic [31:0] blink_cnt;
    logic blink;
    logic cfg_blink;
    logic [`EV_W-1:0] irq_stat;
    logic [`EV_W-1:0] irq_mask;
    logic test_trip;
    logic led_ovl;
    logic led_pre;
    logic led_sel;
    logic led_ins;
    logic led_gnd;
    logic led_pwr;
    logic trip_coil;
    logic irq;
    logic aw_have;
    logic [`AW-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

endpackage : trip_pkg

// File: test/trip_seq_asserts.sv
`timescale 1ns/100ps
`include "trip_params.svh"
module trip_seq_asserts #(
  parameter int RECALL_CYC = 100, // Recall lamp time
  parameter int DEB_CYC = 4 // Debounce time
) (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset, low active
  input wire logic pwr_ok, // Supply good
  input wire logic test_module_present, // Front module
  input wire logic test_trip_req, // Trip test
  input wire logic front_pushbutton, // Button
  input wire logic s_axi_bvalid, // Bus
  input wire logic s_axi_bready, // Bus
  input wire logic [1:0] s_axi_bresp, // Bus
  input wire logic s_axi_arvalid, // Bus
  input wire logic s_axi_arready, // Bus
  input wire logic [`AW-1:0] s_axi_araddr, // Bus
  input wire logic s_axi_rvalid, // Bus
  input wire logic s_axi_rready, // Bus
  input wire logic [1:0] s_axi_rresp, // Bus
  input wire logic led_power, // Power lamp
  input wire logic led_selective, // Selective lamp
  input wire logic trip_coil // Trip command
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic quiet; // Unpowered, button up
  logic [15:0] dark_r; // Quiet cycles, saturating
  assign quiet = !pwr_ok && !test_module_present && !front_pushbutton;
  // Counts quiet time; any recall must have ended long before the limit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) dark_r <= 16'h0;
    else if (!quiet) dark_r <= 16'h0;
    else if (dark_r != 16'hFFFF) dark_r <= dark_r + 16'h1;
  end
  a_dark_quiet: assert property (dark_r > RECALL_CYC + DEB_CYC + 8
    |-> !led_power && !led_selective && !trip_coil) else $error("lamp lit");
  a_power_lamp: assert property (pwr_ok [*4] ##0 !led_power
    |-> ##[1:12] led_power) else $error("power lamp dark");
  a_test_trip: assert property (test_trip_req && test_module_present
    |-> ##2 trip_coil) else $error("test trip missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rresp_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rresp)) else $error("rresp dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read late");
  a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > 8'h10 |=> s_axi_rresp == 2'h2) else $error("no slverr");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
endmodule : trip_seq_asserts
bind trip_unit_panel_sequencer trip_seq_asserts #(.RECALL_CYC(RECALL_CYC),
  .DEB_CYC(DEB_CYC)) chk (.*);

// File: test/panel_operator.sv
`timescale 1ns/100ps
module panel_operator (
  input wire logic clk_sys, // Clock
  input wire logic go, // Start a press
  input wire logic [15:0] len, // Press length, cycles
  output logic front_pushbutton, // High while pressed
  output logic busy // Press under way
);
  logic [15:0] cnt_r = 16'h0; // Cycles left, chatter included
  // Real contacts chatter for three cycles at both ends of a press
  always_ff @(posedge clk_sys) begin
    if (go && !busy) cnt_r <= len + 16'h6;
    else if (busy) cnt_r <= cnt_r - 16'h1;
  end
  assign busy = cnt_r != 16'h0;
  assign front_pushbutton = busy &&
    ((cnt_r > 16'h3 && cnt_r < len + 16'h4) || cnt_r[0]);
endmodule : panel_operator

// File: test/testbench.sv
`timescale 1ns/100ps
`include "trip_params.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
$display("[FAIL] %0t mismatch", $time); end end
module testbench;
  import trip_pkg::*;
  int bad_count = 0; // Mismatches
  int checks_done = 0; // Comparisons
  int cyc = 0; // Cycle count
  logic clk_sys = 1'b0; // Clock
  logic rst_n, ce, pwr_ok, test_module_present, test_trip_req, go, busy;
  logic [15:0] len, rating_amps, meas_phase, meas_neutral, meas_ground;
  set_t sw; // Switch positions
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, front_pushbutton, trip_coil, irq;
  logic [`AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic led_overload, led_overload_pre, led_selective, led_instant;
  logic led_ground, led_power, freq_60hz;
  logic [33:0] notes[$]; // Expected answers, oldest first
  trip_unit_panel_sequencer #(.MS_CYC(4), .HOLD_CYC(50), .RECALL_CYC(100),
    .DEB_CYC(4), .BLINK_CYC(8)) uut (.overload_threshold(sw.thr_l),
    .selective_short_threshold(sw.thr_s), .instantaneous_threshold(sw.thr_i),
    .ground_fault_threshold(sw.thr_g), .overload_delay(sw.dly_l),
    .selective_short_delay(sw.dly_s), .ground_fault_delay(sw.dly_g),
    .curve_sel_short(sw.curve_s), .curve_sel_ground(sw.curve_g),
    .neutral_sel(sw.neutral), .freq_sel_60(sw.freq_60), .*);
  panel_operator op (.*);
  always #2 clk_sys = ~clk_sys;
  // Each bus answer is matched to the oldest note
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      `CHK({s_axi_bresp, 32'h0}, notes.pop_front())
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      `CHK({s_axi_rresp, s_axi_rdata}, notes.pop_front())
  end
  // Verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  // One bus transfer; valid held until its own ready
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [33:0] e);
    int k;
    @(posedge clk_sys);
    notes.push_back(e);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    for (k = 0; k < 60; k++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
        break;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (k == 60) begin bad_count++; results(); end
  endtask : bus
  // Operator press of n cycles, returns after release
  task automatic press(input logic [15:0] n);
    int k;
    @(posedge clk_sys);
    {go, len} <= {1'b1, n};
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    for (k = 0; k < 400 && busy !== 1'b0; k++) @(posedge clk_sys);
    if (k == 400) begin bad_count++; results(); end
  endtask : press
  // Watches n cycles for any trip command
  task automatic no_trip(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin @(posedge clk_sys); seen |= trip_coil !== 1'b0; end
    `CHK(seen, 1'b0)
  endtask : no_trip
  initial begin
    int k;
    int t0;
    void'($urandom(29229));
    {rst_n, ce, pwr_ok, test_module_present, test_trip_req, go} = 6'h10;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, len, meas_phase, meas_neutral, meas_ground} = '0;
    {s_axi_wstrb, rating_amps, sw} = {4'hF, 16'h0064, 30'h0};
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    bus(1'b0, `OFS_CTRL, 32'h0, 34'h0);
    bus(1'b0, 8'h14, 32'h0, {2'h2, 32'h0});
    bus(1'b1, 8'h40, 32'h1, {2'h2, 32'h0});
    press(16'h0014);
    `CHK({led_power, led_selective}, 2'h2)
    repeat (120) @(posedge clk_sys);
    `CHK(led_power, 1'b0)
    // Random switches reach the applied set
    pwr_ok <= 1'b1;
    sw <= set_t'(30'($urandom));
    repeat (20) @(posedge clk_sys);
    bus(1'b0, `OFS_SET, 32'h0, {4'h0, sw});
    `CHK(freq_60hz, sw.freq_60)
    // Selective only: 100 A, 50 ms definite time
    sw <= set_t'(30'h00400000);
    repeat (20) @(posedge clk_sys);
    meas_phase <= 16'h0096;
    t0 = cyc;
    repeat (20) @(posedge clk_sys);
    bus(1'b0, `OFS_STATUS, 32'h0, {2'h0, 32'h00501141});
    sw <= set_t'(30'h00400100);
    repeat (10) @(posedge clk_sys);
    bus(1'b0, `OFS_SET, 32'h0, {2'h0, 32'h00400000});
    for (k = 0; k < 400 && trip_coil !== 1'b1; k++) @(posedge clk_sys);
    `CHK(cyc - t0 inside {[190:215]}, 1'b1)
    if (k == 400) results();
    repeat (2) @(posedge clk_sys);
    `CHK(led_selective, 1'b1)
    bus(1'b0, `OFS_IRQ_STAT, 32'h0, {2'h0, 32'h00000022});
    bus(1'b1, `OFS_IRQ_MASK, 32'h2, 34'h0);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b1)
    meas_phase <= 16'h0;
    repeat (20) @(posedge clk_sys);
    bus(1'b0, `OFS_SET, 32'h0, {2'h0, 32'h00400100});
    bus(1'b1, `OFS_IRQ_STAT, 32'h22, 34'h0);
    repeat (2) @(posedge clk_sys);
    `CHK({irq, trip_coil}, 2'h0)
    bus(1'b1, `OFS_CTRL, 32'h1, 34'h0);
    bus(1'b0, `OFS_CTRL, 32'h0, 34'h1);
    repeat (12) @(posedge clk_sys);
    bus(1'b1, `OFS_CTRL, 32'h0, 34'h0);
    // Overcurrent removed before the 100 ms delay
    meas_phase <= 16'h0096;
    repeat (100) @(posedge clk_sys);
    meas_phase <= 16'h0;
    no_trip(500);
    sw <= set_t'(30'h00000100);
    repeat (20) @(posedge clk_sys);
    meas_phase <= 16'h0096;
    no_trip(600);
    {meas_phase, pwr_ok} <= 17'h0;
    press(16'h0014);
    `CHK({led_power, led_selective}, 2'h1)
    repeat (120) @(posedge clk_sys);
    pwr_ok <= 1'b1;
    repeat (10) @(posedge clk_sys);
    `CHK(led_selective, 1'b1)
    press(16'h0046);
    repeat (10) @(posedge clk_sys);
    `CHK(led_selective, 1'b0)
    // Front module powers the unit and fires a test trip
    {pwr_ok, test_module_present, test_trip_req} <= 3'h3;
    repeat (4) @(posedge clk_sys);
    `CHK({trip_coil, led_power}, 2'h3)
    {ce, test_trip_req} <= 2'h0;
    repeat (5) @(posedge clk_sys);
    `CHK(trip_coil, 1'b1)
    results();
  end
endmodule : testbench
